// ==== core/pic_ctrl.sv ====
// prioritised interrupt controller with fast and normal core requests
// Operation
// - eight-level priority encoder; highest-level pending source is presented first
// - two request outputs drive the core fast and normal interrupt inputs
// - fast request asserts only from the external fast request pin
// - normal request asserts from any peripheral source or external general pin
// - each source is programmable level sensitive or edge sensitive
// - external sources also select rising/falling edge or high/low level
// - each parallel i/o line may raise an interrupt on input change
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pic_ctrl #(
	parameter int NPER = 4,
	parameter int IO_W = 12
) (
	// clock, reset, clock enable
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic ce,
	// register port
	input wire pic_pkg::pic_bus_req_t bus_req,
	output logic [pic_pkg::DATA_W-1:0] bus_rdata,
	// interrupt sources
	input wire logic ext_fast_request_pin,
	input wire logic ext_general_request_pin,
	input wire logic [NPER-1:0] periph_irq,
	input wire logic [IO_W-1:0] pio_first_in,
	input wire logic [IO_W-1:0] pio_second_in,
	// requests to the core
	output logic core_fast_request,
	output logic core_normal_request,
	output pic_pkg::pic_cur_t cur_src
);
	localparam int NSRC = pic_pkg::SRC_FIXED + NPER;

	if (NPER < 1 || NSRC > pic_pkg::MAX_SRC || IO_W < 1 || IO_W > 32) begin : g_bad_params
		$error("pic_ctrl: NPER or IO_W outside what the register map can hold");
	end

	logic [NSRC-1:0] en_q, en_d;
	logic [NSRC-1:0] mode_q, mode_d;
	logic [pic_pkg::EXT_SRC-1:0] pol_q, pol_d;
	logic [NSRC-1:0] status_q, status_d;
	logic [NSRC-1:0] prev_q, prev_d;
	logic [pic_pkg::PRIO_W*NSRC-1:0] prio_q, prio_d;
	logic [IO_W-1:0] pio_mask_a_q, pio_mask_a_d;
	logic [IO_W-1:0] pio_mask_b_q, pio_mask_b_d;
	pic_pkg::pic_cur_t cur_q, cur_d;
	logic [pic_pkg::DATA_W-1:0] rdata_q, rdata_d;

	logic chg_a, chg_b;
	logic [NSRC-1:0] act;
	logic [NSRC-1:0] set_evt;
	logic [NSRC-1:0] clr;
	logic [NSRC-1:0] cand;

	// per-bank change detectors feed one source each
	pic_chg_det #(
		.IO_W(IO_W)
	) u_pio_first (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.ce(ce),
		.io_in(pio_first_in),
		.mask(pio_mask_a_q),
		.change(chg_a)
	);

	pic_chg_det #(
		.IO_W(IO_W)
	) u_pio_second (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.ce(ce),
		.io_in(pio_second_in),
		.mask(pio_mask_b_q),
		.change(chg_b)
	);

	// packs the priority fields of one register word
	function automatic logic [pic_pkg::DATA_W-1:0] prio_word(
		input logic [pic_pkg::PRIO_W*NSRC-1:0] p,
		input int w
	);
		logic [pic_pkg::DATA_W-1:0] r;
		r = '0;
		for (int i = 0; i < NSRC; i++) begin
			if (i / pic_pkg::PRIO_PER_WORD == w) begin
				r[pic_pkg::PRIO_W*(i%pic_pkg::PRIO_PER_WORD)+:pic_pkg::PRIO_W] =
					p[pic_pkg::PRIO_W*i+:pic_pkg::PRIO_W];
			end
		end
		return r;
	endfunction : prio_word

	// highest level wins; equal levels go to the lower source number
	function automatic pic_pkg::pic_cur_t pick(
		input logic [NSRC-1:0] c,
		input logic [pic_pkg::PRIO_W*NSRC-1:0] p
	);
		pic_pkg::pic_cur_t r;
		r = '0;
		for (int i = 0; i < NSRC; i++) begin
			if (c[i] && (!r.valid || p[pic_pkg::PRIO_W*i+:pic_pkg::PRIO_W] > r.lvl)) begin
				r.valid = 1'b1;
				r.lvl = p[pic_pkg::PRIO_W*i+:pic_pkg::PRIO_W];
				r.src = pic_pkg::SRC_IDX_W'(i);
			end
		end
		return r;
	endfunction : pick

	// external pins: polarity bit high means high level or rising edge
	always_comb begin
		act = '0;
		act[pic_pkg::SRC_FAST] = ~(ext_fast_request_pin ^ pol_q[pic_pkg::SRC_FAST]);
		act[pic_pkg::SRC_GEN] = ~(ext_general_request_pin ^ pol_q[pic_pkg::SRC_GEN]);
		act[pic_pkg::SRC_PARALLEL_IO_CTRL_FIRST] = chg_a;
		act[pic_pkg::SRC_PARALLEL_IO_CTRL_SECOND] = chg_b;
		act[NSRC-1:pic_pkg::SRC_FIXED] = periph_irq;
	end

	// edge sources fire once per transition, level sources every active cycle
	assign set_evt = (mode_q & act & ~prev_q) | (~mode_q & act);

	assign clr = (bus_req.wr && bus_req.addr == pic_pkg::OFS_STATUS) ?
		bus_req.wdata[NSRC-1:0] : '0;

	// fast source is kept out of the normal path entirely
	always_comb begin
		cand = status_q & en_q;
		cand[pic_pkg::SRC_FAST] = 1'b0;
	end

	assign core_fast_request = status_q[pic_pkg::SRC_FAST] && en_q[pic_pkg::SRC_FAST];
	assign core_normal_request = |cand;
	assign cur_src = cur_q;
	assign bus_rdata = rdata_q;

	always_comb begin
		en_d = en_q;
		mode_d = mode_q;
		pol_d = pol_q;
		prio_d = prio_q;
		pio_mask_a_d = pio_mask_a_q;
		pio_mask_b_d = pio_mask_b_q;
		prev_d = act;
		// a level held active keeps re-setting its bit, so a clear only sticks once released
		status_d = (status_q & ~clr) | set_evt;
		cur_d = pick(cand, prio_q);
		rdata_d = '0;
		if (bus_req.wr) begin
			case (bus_req.addr)
				pic_pkg::OFS_ENABLE: en_d = bus_req.wdata[NSRC-1:0];
				pic_pkg::OFS_MODE: mode_d = bus_req.wdata[NSRC-1:0];
				pic_pkg::OFS_POLARITY: pol_d = bus_req.wdata[pic_pkg::EXT_SRC-1:0];
				pic_pkg::OFS_PIO_MASK_A: pio_mask_a_d = bus_req.wdata[IO_W-1:0];
				pic_pkg::OFS_PIO_MASK_B: pio_mask_b_d = bus_req.wdata[IO_W-1:0];
				pic_pkg::OFS_PRIO0, pic_pkg::OFS_PRIO1: begin
					for (int i = 0; i < NSRC; i++) begin
						if ((i / pic_pkg::PRIO_PER_WORD == 0) == (bus_req.addr == pic_pkg::OFS_PRIO0)) begin
							prio_d[pic_pkg::PRIO_W*i+:pic_pkg::PRIO_W] = bus_req.wdata[
								pic_pkg::PRIO_W*(i%pic_pkg::PRIO_PER_WORD)+:pic_pkg::PRIO_W];
						end
					end
				end
				default: ;
			endcase
		end
		if (bus_req.rd) begin
			case (bus_req.addr)
				pic_pkg::OFS_ENABLE: rdata_d = pic_pkg::DATA_W'(en_q);
				pic_pkg::OFS_MODE: rdata_d = pic_pkg::DATA_W'(mode_q);
				pic_pkg::OFS_POLARITY: rdata_d = pic_pkg::DATA_W'(pol_q);
				pic_pkg::OFS_STATUS: rdata_d = pic_pkg::DATA_W'(status_q);
				pic_pkg::OFS_PRIO0: rdata_d = prio_word(prio_q, 0);
				pic_pkg::OFS_PRIO1: rdata_d = prio_word(prio_q, 1);
				pic_pkg::OFS_PIO_MASK_A: rdata_d = pic_pkg::DATA_W'(pio_mask_a_q);
				pic_pkg::OFS_PIO_MASK_B: rdata_d = pic_pkg::DATA_W'(pio_mask_b_q);
				pic_pkg::OFS_CURRENT: begin
					rdata_d[pic_pkg::CUR_SRC_LSB+:pic_pkg::SRC_IDX_W] = cur_q.src;
					rdata_d[pic_pkg::CUR_LVL_LSB+:pic_pkg::PRIO_W] = cur_q.lvl;
					rdata_d[pic_pkg::CUR_VALID_BIT] = cur_q.valid;
				end
				default: rdata_d = '0;
			endcase
		end
	end

	// clock enable low freezes every flop, bus accesses included
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			en_q <= NSRC'(pic_pkg::RST_ENABLE);
			mode_q <= NSRC'(pic_pkg::RST_MODE);
			pol_q <= pic_pkg::RST_POLARITY;
			status_q <= '0;
			prev_q <= '0;
			prio_q <= '0;
			pio_mask_a_q <= IO_W'(pic_pkg::RST_PIO_MASK);
			pio_mask_b_q <= IO_W'(pic_pkg::RST_PIO_MASK);
			cur_q <= '0;
			rdata_q <= '0;
		end else if (ce) begin
			en_q <= en_d;
			mode_q <= mode_d;
			pol_q <= pol_d;
			status_q <= status_d;
			prev_q <= prev_d;
			prio_q <= prio_d;
			pio_mask_a_q <= pio_mask_a_d;
			pio_mask_b_q <= pio_mask_b_d;
			cur_q <= cur_d;
			rdata_q <= rdata_d;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	// only the fast pin may ever set the fast pending bit
	AST_FAST_FROM_PIN_ONLY: assert property (
		$rose(status_q[pic_pkg::SRC_FAST]) |-> $past(act[pic_pkg::SRC_FAST]))
		else $error("fast pending bit set without the fast pin active");

	AST_FAST_NOT_ON_NORMAL: assert property (
		(status_q & en_q & ~NSRC'(1)) == '0 |-> !core_normal_request)
		else $error("normal request raised by the fast source alone");

	AST_GEN_LEVEL_RAISES_NORMAL: assert property (
		(ce && en_q[pic_pkg::SRC_GEN] && !mode_q[pic_pkg::SRC_GEN]
			&& act[pic_pkg::SRC_GEN] && !bus_req.wr) |=> core_normal_request)
		else $error("active general pin did not raise the normal request");

	AST_DISABLED_STILL_PENDS: assert property (
		(ce && set_evt != '0) |=> (status_q & $past(set_evt)) == $past(set_evt))
		else $error("source event not recorded as pending");

	AST_DISABLED_SILENT: assert property (
		!en_q[pic_pkg::SRC_FAST] |-> !core_fast_request)
		else $error("disabled fast source drove the fast request");

	AST_EDGE_ONCE: assert property (
		(mode_q & set_evt & ~(act & ~prev_q)) == '0)
		else $error("edge source set without a transition");

	AST_LOW_LEVEL_POLARITY: assert property (
		(ce && !mode_q[pic_pkg::SRC_FAST] && !pol_q[pic_pkg::SRC_FAST]
			&& !ext_fast_request_pin && en_q[pic_pkg::SRC_FAST]
			&& !bus_req.wr) |=> core_fast_request)
		else $error("low level on fast pin with low polarity not seen");

	AST_PIO_CHANGE_PENDS: assert property (
		(ce && chg_a) |=> status_q[pic_pkg::SRC_PARALLEL_IO_CTRL_FIRST])
		else $error("parallel i/o change did not set its pending bit");

	// shift the past vectors by today's source; indexing inside past would use the old source
	AST_PRIO_PRESENTED: assert property (
		(ce && cand != '0) |=> cur_q.valid && 1'($past(cand) >> cur_q.src)
			&& pic_pkg::PRIO_W'($past(prio_q) >> (pic_pkg::PRIO_W * cur_q.src)) == cur_q.lvl)
		else $error("presented source was not a pending candidate at its level");
endmodule : pic_ctrl
`default_nettype wire

// ==== include/pic_pkg.sv ====
// constants and carrier types of the prioritised interrupt controller
`default_nettype none
package pic_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int MAX_SRC = 16;
	localparam int SRC_IDX_W = 4;
	localparam int PRIO_W = 3;
	localparam int LEVELS = 8;
	localparam int PRIO_PER_WORD = 8;
	localparam int EXT_SRC = 2;

	// register offsets, byte addresses
	localparam logic [7:0] OFS_ENABLE = 8'h00;
	localparam logic [7:0] OFS_MODE = 8'h04;
	localparam logic [7:0] OFS_POLARITY = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_PRIO0 = 8'h10;
	localparam logic [7:0] OFS_PRIO1 = 8'h14;
	localparam logic [7:0] OFS_CURRENT = 8'h18;
	localparam logic [7:0] OFS_PIO_MASK_A = 8'h1c;
	localparam logic [7:0] OFS_PIO_MASK_B = 8'h20;

	// reset values
	localparam logic [31:0] RST_ENABLE = 32'h0000_0000;
	localparam logic [31:0] RST_MODE = 32'h0000_0000;
	localparam logic [1:0] RST_POLARITY = 2'h3;
	localparam logic [31:0] RST_PIO_MASK = 32'h0000_0000;

	// source numbering
	localparam int SRC_FAST = 0;
	localparam int SRC_GEN = 1;
	localparam int SRC_PARALLEL_IO_CTRL_FIRST = 2;
	localparam int SRC_PARALLEL_IO_CTRL_SECOND = 3;
	localparam int SRC_FIXED = 4;

	// fields of the current-source register
	localparam int CUR_SRC_LSB = 0;
	localparam int CUR_LVL_LSB = 8;
	localparam int CUR_VALID_BIT = 31;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} pic_bus_req_t;

	typedef struct packed {
		logic valid;
		logic [PRIO_W-1:0] lvl;
		logic [SRC_IDX_W-1:0] src;
	} pic_cur_t;
endpackage : pic_pkg
`default_nettype wire

// ==== core/pic_chg_det.sv ====
// input-change detector for one bank of parallel i/o lines
`timescale 1ns/1ps
`default_nettype none
module pic_chg_det #(
	parameter int IO_W = 12
) (
	// clock, reset and clock enable
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic ce,
	// lines and per-line change enable
	input wire logic [IO_W-1:0] io_in,
	input wire logic [IO_W-1:0] mask,
	// one-cycle change event
	output logic change
);
	logic [IO_W-1:0] prev_q, prev_d;
	logic armed_q, armed_d;

	if (IO_W < 1 || IO_W > 32) begin : g_bad_width
		$error("pic_chg_det: IO_W must be 1 to 32");
	end

	// no compare until one sample is held, so reset is not seen as a change
	always_comb begin
		prev_d = io_in;
		armed_d = 1'b1;
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			prev_q <= '0;
			armed_q <= 1'b0;
		end else if (ce) begin
			prev_q <= prev_d;
			armed_q <= armed_d;
		end
	end

	assign change = ce && armed_q && |((io_in ^ prev_q) & mask);

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	AST_CHG_ONLY_MASKED: assert property (
		change |-> ((io_in ^ prev_q) & mask) != '0 && armed_q)
		else $error("change event without a masked line change");
endmodule : pic_chg_det
`default_nettype wire

// ==== tb/pic_core_model.sv ====
// partner model of the core side: samples both request inputs
`timescale 1ns/1ps
`default_nettype none
module pic_core_model (
	// clock
	input wire logic sys_clk,
	// requests from the controller
	input wire logic core_fast_request,
	input wire logic core_normal_request,
	// levels as the core took them at its last edge
	output logic fast_taken,
	output logic normal_taken
);
	// the core only looks at its inputs on its clock edge, so a glitch never counts
	always_ff @(posedge sys_clk) begin
		fast_taken <= core_fast_request;
		normal_taken <= core_normal_request;
	end
endmodule : pic_core_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench of the prioritised interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	pic_pkg::pic_bus_req_t bus_req = '0;
	logic [31:0] bus_rdata;
	logic fpin = 1'b0;
	logic gpin = 1'b0;
	logic [3:0] periph_irq = 4'h0;
	logic [11:0] pio_a = 12'h000;
	logic [11:0] pio_b = 12'h000;
	logic core_fast_request;
	logic core_normal_request;
	logic fast_taken;
	logic normal_taken;
	pic_pkg::pic_cur_t cur_src;
	int error_cnt = 0;
	int total_checks = 0;
	logic [31:0] rv;

	always #12.5 sys_clk = ~sys_clk;

	pic_ctrl #(.NPER(4), .IO_W(12)) i_pic_ctrl (.sys_clk(sys_clk), .resetn(resetn), .ce(1'b1),
		.bus_req(bus_req), .bus_rdata(bus_rdata), .ext_fast_request_pin(fpin),
		.ext_general_request_pin(gpin), .periph_irq(periph_irq), .pio_first_in(pio_a),
		.pio_second_in(pio_b), .core_fast_request(core_fast_request),
		.core_normal_request(core_normal_request), .cur_src(cur_src));
	pic_core_model i_pic_core_model (.sys_clk(sys_clk), .core_fast_request(core_fast_request),
		.core_normal_request(core_normal_request), .fast_taken(fast_taken),
		.normal_taken(normal_taken));

	task automatic report_and_stop;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s exp %h got %h", n, e, g);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		bus_req.wr <= 1'b0;
	endtask : wr

	// ends on an edge so that callers can drive pins right after it
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		bus_req.rd <= 1'b0;
		#1;
		d = bus_rdata;
		@(posedge sys_clk);
	endtask : rd

	task automatic chk_reg(input string n, input logic [7:0] a, input logic [31:0] e);
		rd(a, rv);
		chk(n, e, rv);
	endtask : chk_reg

	// e is {fast, normal} as the core saw them
	task automatic chk_req(input logic [1:0] e);
		#1;
		chk("requests", {30'h0, e}, {30'h0, fast_taken, normal_taken});
		@(posedge sys_clk);
	endtask : chk_req

	// cur_src is a flop output: look just after the edge that launched it
	task automatic chk_cur(input logic [7:0] e);
		#1;
		chk("cur_src", {24'h0, e}, {24'h0, cur_src});
	endtask : chk_cur

	task automatic wait_normal;
		int i;
		for (i = 0; i < 8; i++) begin
			@(posedge sys_clk);
			#1;
			if (normal_taken === 1'b1) break;
		end
		if (i == 8) begin
			error_cnt++;
			report_and_stop();
		end
	endtask : wait_normal

	initial begin
		tick(16);
		resetn <= 1'b1;
		tick(1);
		chk_reg("enable", pic_pkg::OFS_ENABLE, pic_pkg::RST_ENABLE);
		chk_reg("polarity", pic_pkg::OFS_POLARITY, {30'h0, pic_pkg::RST_POLARITY});
		chk_reg("unmapped", 8'h40, 32'h0);
		// general pin, level high, level 3
		wr(pic_pkg::OFS_ENABLE, 32'h0000_0003);
		wr(pic_pkg::OFS_PRIO0, 32'h0000_0018);
		gpin <= 1'b1;
		wait_normal();
		chk_cur(8'hb1);
		chk_req(2'b01);
		chk_reg("current", pic_pkg::OFS_CURRENT, 32'h8000_0301);
		gpin <= 1'b0;
		wr(pic_pkg::OFS_STATUS, 32'h2);
		tick(2);
		chk_req(2'b00);
		// fast pin reaches only the fast request
		fpin <= 1'b1;
		tick(3);
		chk_cur(8'h00);
		chk_req(2'b10);
		fpin <= 1'b0;
		wr(pic_pkg::OFS_STATUS, 32'h1);
		tick(2);
		// disabled peripheral pends without a request
		periph_irq <= 4'h1;
		tick(3);
		chk_reg("status", pic_pkg::OFS_STATUS, 32'h10);
		chk_req(2'b00);
		wr(pic_pkg::OFS_ENABLE, 32'h0000_0033);
		tick(2);
		chk_req(2'b01);
		// two peripherals, the higher level wins either way round
		wr(pic_pkg::OFS_PRIO0, 32'h0002_a000);
		periph_irq <= 4'h3;
		tick(3);
		chk_reg("current", pic_pkg::OFS_CURRENT, 32'h8000_0505);
		wr(pic_pkg::OFS_PRIO0, 32'h0000_e000);
		tick(2);
		chk_reg("current", pic_pkg::OFS_CURRENT, 32'h8000_0604);
		periph_irq <= 4'h0;
		wr(pic_pkg::OFS_STATUS, 32'h30);
		tick(2);
		chk_reg("status", pic_pkg::OFS_STATUS, 32'h0);
		// general pin as falling edge
		gpin <= 1'b1;
		wr(pic_pkg::OFS_POLARITY, 32'h1);
		wr(pic_pkg::OFS_MODE, 32'h2);
		wr(pic_pkg::OFS_STATUS, 32'h2);
		tick(2);
		chk_reg("status", pic_pkg::OFS_STATUS, 32'h0);
		gpin <= 1'b0;
		tick(3);
		chk_reg("status", pic_pkg::OFS_STATUS, 32'h2);
		wr(pic_pkg::OFS_STATUS, 32'h2);
		tick(2);
		chk_reg("status", pic_pkg::OFS_STATUS, 32'h0);
		// change on a masked-out line is ignored, on a masked-in line it pends
		wr(pic_pkg::OFS_PIO_MASK_A, 32'h1);
		wr(pic_pkg::OFS_ENABLE, 32'h4);
		pio_a <= 12'h002;
		tick(3);
		chk_reg("status", pic_pkg::OFS_STATUS, 32'h0);
		pio_a <= 12'h003;
		tick(3);
		chk_reg("status", pic_pkg::OFS_STATUS, 32'h4);
		chk_req(2'b01);
		// second bank reaches its own source
		wr(pic_pkg::OFS_PIO_MASK_B, 32'h800);
		pio_b <= 12'h800;
		tick(3);
		chk_reg("status", pic_pkg::OFS_STATUS, 32'hc);
		// fast pin as low level: the quiet low pin now requests
		wr(pic_pkg::OFS_ENABLE, 32'h1);
		wr(pic_pkg::OFS_POLARITY, 32'h2);
		tick(2);
		chk_req(2'b10);
		chk_reg("status", pic_pkg::OFS_STATUS, 32'hd);
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
